//--- rtl/tsq_core.sv
// trigger sequencer core: apb registers, step queue, pointer, loop counters
// assumes a plain apb master on pclk; clock source pins are asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "tsq_params.svh"
module tsq_core #(
    parameter int QDEPTH = 32,
    parameter int PW = 5,
    parameter int CW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_clk,
    input wire logic pwm_clk,
    input wire logic ext_clk,
    output logic seq_busy,
    output logic step_strobe,
    output logic [7:0] step_code
);
    logic module_enable_r;
    logic en_d_r;
    logic counter_visibility_select_r;
    logic sequencer_run_r;
    logic [2:0] clock_source_select_r;
    logic [4:0] clock_prescale_ratio_r;
    logic [PW-1:0] queue_pointer_r;
    logic [PW-1:0] live_ptr_r;
    logic [CW-1:0] loop_counter_limit_r [2];
    logic [CW-1:0] loop_counter_r [2];
    logic [CW-1:0] hold_r;
    logic [CW-1:0] adjust_r;
    logic [7:0] queue_r [QDEPTH];
    tsq_pkg::tsq_state_t state_r;
    logic [2:0] dly_r;
    logic seq_tick;
    logic acc;
    logic wr;
    logic rd_phase;
    tsq_pkg::tsq_rsel_t rsel;
    logic [31:0] rd_word;
    logic [7:0] cmd;
    logic exec_go;
    logic jc_hit [2];
    logic jc_taken [2];
    logic en_fall;
    logic flow_change;
    logic vis_live;

    function automatic tsq_pkg::tsq_rsel_t decode(input logic [7:0] a);
        tsq_pkg::tsq_rsel_t s;
        s = tsq_pkg::TSQ_RS_NONE;
        if (a[`TSQ_QUEUE_BIT]) begin
            if (a[1:0] == 2'h0 && int'(a[6:2]) < QDEPTH) s = tsq_pkg::TSQ_RS_QUEUE;
        end else begin
            unique case (a)
                `TSQ_ADDR_MAIN: s = tsq_pkg::TSQ_RS_MAIN;
                `TSQ_ADDR_CLK: s = tsq_pkg::TSQ_RS_CLK;
                `TSQ_ADDR_QPTR: s = tsq_pkg::TSQ_RS_QPTR;
                `TSQ_ADDR_LIM0: s = tsq_pkg::TSQ_RS_LIM0;
                `TSQ_ADDR_LIM1: s = tsq_pkg::TSQ_RS_LIM1;
                `TSQ_ADDR_HOLD: s = tsq_pkg::TSQ_RS_HOLD;
                `TSQ_ADDR_ADJ: s = tsq_pkg::TSQ_RS_ADJ;
                default: s = tsq_pkg::TSQ_RS_NONE;
            endcase
        end
        return s;
    endfunction : decode

    // unconditional jump, code 101x; target is the low five bits
    function automatic logic is_uncond_jump(input logic [7:0] c);
        return c[7:5] == 3'b101;
    endfunction : is_uncond_jump

    // conditional jump, code 11sx; s names the loop counter tested
    function automatic logic is_cond_jump(input logic [7:0] c, input logic sel);
        return c[7:6] == 2'b11 && c[5] == sel;
    endfunction : is_cond_jump

    // adjust code 0100; the option names the limit and add or copy
    function automatic logic is_adjust(input logic [7:0] c, input logic [3:0] opt);
        return c[7:4] == tsq_pkg::TSQ_CMD_ADJUST && c[3:0] == opt;
    endfunction : is_adjust

    // limit reads show the live counter only while enabled with visibility set
    function automatic logic [CW-1:0] limit_view(
        input logic live,
        input logic [CW-1:0] lim,
        input logic [CW-1:0] cnt
    );
        logic [CW-1:0] v;
        v = lim;
        if (live) v = cnt;
        return v;
    endfunction : limit_view

    // prescaler restarts on every enable, so the start-up count begins clean
    tsq_clkgen #(
        .DIV_W(5)
    ) u_clkgen (
        .pclk(pclk),
        .presetn(presetn),
        .enable(module_enable_r),
        .src_sel(clock_source_select_r),
        .div(clock_prescale_ratio_r),
        .conv_clk(conv_clk),
        .pwm_clk(pwm_clk),
        .ext_clk(ext_clk),
        .tick(seq_tick)
    );

    // one wait state: the answer registers settle before pready is shown
    assign rsel = decode(paddr);
    assign rd_phase = psel & penable & ~pready;
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite & (rsel != tsq_pkg::TSQ_RS_NONE);
    assign en_fall = en_d_r & ~module_enable_r;
    assign cmd = queue_r[live_ptr_r];
    assign exec_go = (state_r == tsq_pkg::TSQ_ST_EXEC) & sequencer_run_r & seq_tick;
    assign flow_change = is_uncond_jump(cmd) | jc_taken[0] | jc_taken[1];
    assign vis_live = module_enable_r & counter_visibility_select_r;

    // pointer, limit, hold, adjust and queue values read back in the low bits, other bits zero
    always_comb begin
        rd_word = `TSQ_RESET_WORD;
        unique case (rsel)
            tsq_pkg::TSQ_RS_MAIN: begin
                rd_word[`TSQ_BIT_EN] = module_enable_r;
                rd_word[`TSQ_BIT_VIS] = counter_visibility_select_r;
                rd_word[`TSQ_BIT_RUN] = sequencer_run_r;
            end
            tsq_pkg::TSQ_RS_CLK: begin
                rd_word[`TSQ_SRC_HI:`TSQ_SRC_LO] = clock_source_select_r;
                rd_word[`TSQ_DIV_HI:`TSQ_DIV_LO] = clock_prescale_ratio_r;
            end
            tsq_pkg::TSQ_RS_QPTR: rd_word[PW-1:0] = module_enable_r ? live_ptr_r
                                                                    : queue_pointer_r;
            tsq_pkg::TSQ_RS_LIM0: begin
                rd_word[CW-1:0] = limit_view(vis_live, loop_counter_limit_r[0],
                                             loop_counter_r[0]);
            end
            tsq_pkg::TSQ_RS_LIM1: begin
                rd_word[CW-1:0] = limit_view(vis_live, loop_counter_limit_r[1],
                                             loop_counter_r[1]);
            end
            tsq_pkg::TSQ_RS_HOLD: rd_word[CW-1:0] = hold_r;
            tsq_pkg::TSQ_RS_ADJ: rd_word[CW-1:0] = adjust_r;
            tsq_pkg::TSQ_RS_QUEUE: rd_word[7:0] = queue_r[paddr[PW+1:2]];
            default: rd_word = `TSQ_RESET_WORD;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `TSQ_RESET_WORD;
        end else begin
            pready <= rd_phase;
            // unmapped addresses still take the one wait state, then flag an error
            pslverr <= rd_phase & (rsel == tsq_pkg::TSQ_RS_NONE);
            if (rd_phase && !pwrite) prdata <= rd_word;
        end
    end

    // main control/status stays writable while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_enable_r <= 1'b0;
            en_d_r <= 1'b0;
            counter_visibility_select_r <= 1'b0;
            sequencer_run_r <= 1'b0;
        end else begin
            en_d_r <= module_enable_r;
            if (wr && rsel == tsq_pkg::TSQ_RS_MAIN) begin
                module_enable_r <= pwdata[`TSQ_BIT_EN];
                counter_visibility_select_r <= pwdata[`TSQ_BIT_VIS];
                // run only sticks once enable is already set
                sequencer_run_r <= pwdata[`TSQ_BIT_RUN] & pwdata[`TSQ_BIT_EN]
                                   & module_enable_r;
            end
        end
    end

    // clock, hold and adjust registers lock while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_source_select_r <= 3'h0;
            clock_prescale_ratio_r <= 5'h00;
            hold_r <= '0;
            adjust_r <= '0;
        end else if (wr && !module_enable_r) begin
            if (rsel == tsq_pkg::TSQ_RS_CLK) begin
                clock_source_select_r <= pwdata[`TSQ_SRC_HI:`TSQ_SRC_LO];
                clock_prescale_ratio_r <= pwdata[`TSQ_DIV_HI:`TSQ_DIV_LO];
            end
            if (rsel == tsq_pkg::TSQ_RS_HOLD) hold_r <= pwdata[CW-1:0];
            if (rsel == tsq_pkg::TSQ_RS_ADJ) adjust_r <= pwdata[CW-1:0];
        end
    end

    // queue storage; loaded only while disabled so a running program is stable
    always_ff @(posedge pclk) begin
        if (wr && !module_enable_r && rsel == tsq_pkg::TSQ_RS_QUEUE) begin
            queue_r[paddr[PW+1:2]] <= pwdata[7:0];
        end
    end

    // stored pointer register: software any time, cleared once on disable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            queue_pointer_r <= '0;
        end else if (wr && rsel == tsq_pkg::TSQ_RS_QPTR) begin
            queue_pointer_r <= pwdata[PW-1:0];
        end else if (en_fall) begin
            queue_pointer_r <= '0;
        end else if (state_r == tsq_pkg::TSQ_ST_EXEC && !sequencer_run_r) begin
            queue_pointer_r <= live_ptr_r;
        end
    end

    // enable delay, halt, execute and the extra tick of a flow change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= tsq_pkg::TSQ_ST_OFF;
            dly_r <= 3'h0;
        end else if (!module_enable_r) begin
            state_r <= tsq_pkg::TSQ_ST_OFF;
            dly_r <= 3'h0;
        end else begin
            unique case (state_r)
                tsq_pkg::TSQ_ST_OFF: begin
                    state_r <= tsq_pkg::TSQ_ST_DELAY;
                    dly_r <= 3'h1;
                end
                tsq_pkg::TSQ_ST_DELAY: begin
                    if (seq_tick) begin
                        dly_r <= dly_r + 3'h1;
                        if (dly_r == `TSQ_ENABLE_DELAY_TICKS) begin
                            state_r <= tsq_pkg::TSQ_ST_HALT;
                        end
                    end
                end
                tsq_pkg::TSQ_ST_HALT: begin
                    if (sequencer_run_r) state_r <= tsq_pkg::TSQ_ST_EXEC;
                end
                tsq_pkg::TSQ_ST_EXEC: begin
                    if (!sequencer_run_r) begin
                        state_r <= tsq_pkg::TSQ_ST_HALT;
                    end else if (seq_tick) begin
                        if (flow_change) begin
                            state_r <= tsq_pkg::TSQ_ST_FLUSH;
                        end
                    end
                end
                tsq_pkg::TSQ_ST_FLUSH: begin
                    if (seq_tick) state_r <= tsq_pkg::TSQ_ST_EXEC;
                end
                default: state_r <= tsq_pkg::TSQ_ST_OFF;
            endcase
        end
    end

    // live pointer: loaded at start, stepped or jumped each executed step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_ptr_r <= '0;
        end else if (!module_enable_r) begin
            live_ptr_r <= '0;
        end else if (state_r == tsq_pkg::TSQ_ST_HALT && sequencer_run_r) begin
            live_ptr_r <= queue_pointer_r;
        end else if (exec_go) begin
            if (flow_change) begin
                live_ptr_r <= {cmd[4:0]};
            end else begin
                live_ptr_r <= live_ptr_r + 1'b1;
            end
        end
    end

    // counter select is the third code bit, so either may nest inside the other
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_loop
            assign jc_hit[g] = exec_go && is_cond_jump(cmd, 1'(g));
            // inequality, not below: a limit under the count runs on until the count wraps
            assign jc_taken[g] = jc_hit[g]
                                 && loop_counter_r[g] != loop_counter_limit_r[g];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    loop_counter_r[g] <= '0;
                end else if (!module_enable_r) begin
                    loop_counter_r[g] <= '0;
                end else if (jc_taken[g]) begin
                    loop_counter_r[g] <= loop_counter_r[g] + 1'b1;
                end else if (jc_hit[g]) begin
                    loop_counter_r[g] <= '0;
                end
            end

            // wrap on add is accepted; the limit is a plain 16-bit sum
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    loop_counter_limit_r[g] <= '0;
                end else if (!module_enable_r) begin
                    if (wr && rsel == (g == 0 ? tsq_pkg::TSQ_RS_LIM0 : tsq_pkg::TSQ_RS_LIM1)) begin
                        loop_counter_limit_r[g] <= pwdata[CW-1:0];
                    end
                end else if (exec_go) begin
                    if (is_adjust(cmd, g == 0 ? `TSQ_OPT_ADD_LIM0 : `TSQ_OPT_ADD_LIM1)) begin
                        loop_counter_limit_r[g] <= loop_counter_limit_r[g] + adjust_r;
                    end
                    if (is_adjust(cmd, g == 0 ? `TSQ_OPT_COPY_LIM0 : `TSQ_OPT_COPY_LIM1)) begin
                        loop_counter_limit_r[g] <= hold_r;
                    end
                end
            end
        end
    endgenerate

    // step outputs registered; the code holds until the next executed step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_busy <= 1'b0;
            step_strobe <= 1'b0;
            step_code <= 8'h00;
        end else begin
            seq_busy <= state_r == tsq_pkg::TSQ_ST_EXEC || state_r == tsq_pkg::TSQ_ST_FLUSH;
            step_strobe <= exec_go;
            if (exec_go) step_code <= cmd;
        end
    end
endmodule : tsq_core
`default_nettype wire

//--- rtl/tsq_params.svh
// constants of the trigger sequencer core: offsets, fields, resets, counts
// assumes inclusion by the core, the clock generator, the checker and the bench
`ifndef TSQ_PARAMS_SVH
`define TSQ_PARAMS_SVH
`define TSQ_ADDR_MAIN 8'h00
`define TSQ_ADDR_CLK 8'h04
`define TSQ_ADDR_QPTR 8'h08
`define TSQ_ADDR_LIM0 8'h0C
`define TSQ_ADDR_LIM1 8'h10
`define TSQ_ADDR_HOLD 8'h14
`define TSQ_ADDR_ADJ 8'h18
`define TSQ_QUEUE_BIT 7
`define TSQ_BIT_EN 15
`define TSQ_BIT_VIS 8
`define TSQ_BIT_RUN 7
`define TSQ_SRC_HI 15
`define TSQ_SRC_LO 13
`define TSQ_DIV_HI 12
`define TSQ_DIV_LO 8
`define TSQ_ENABLE_DELAY_TICKS 3'h4
`define TSQ_OPT_ADD_LIM0 4'h0
`define TSQ_OPT_ADD_LIM1 4'h1
`define TSQ_OPT_COPY_LIM0 4'h8
`define TSQ_OPT_COPY_LIM1 4'h9
`define TSQ_RESET_WORD 32'h0000_0000
`endif

//--- rtl/tsq_pkg.sv
// types of the trigger sequencer core
// assumes nothing outside itself
package tsq_pkg;
    typedef enum logic [2:0] {
        TSQ_ST_OFF = 3'b000,
        TSQ_ST_DELAY = 3'b001,
        TSQ_ST_HALT = 3'b010,
        TSQ_ST_EXEC = 3'b011,
        TSQ_ST_FLUSH = 3'b100
    } tsq_state_t;
    typedef enum logic [3:0] {
        TSQ_CMD_ADJUST = 4'h4,
        TSQ_CMD_JMP0 = 4'hA,
        TSQ_CMD_JMP1 = 4'hB,
        TSQ_CMD_JC0A = 4'hC,
        TSQ_CMD_JC0B = 4'hD,
        TSQ_CMD_JC1A = 4'hE,
        TSQ_CMD_JC1B = 4'hF
    } tsq_cmd_t;
    typedef enum logic [3:0] {
        TSQ_RS_MAIN, TSQ_RS_CLK, TSQ_RS_QPTR, TSQ_RS_LIM0, TSQ_RS_LIM1,
        TSQ_RS_HOLD, TSQ_RS_ADJ, TSQ_RS_QUEUE, TSQ_RS_NONE
    } tsq_rsel_t;
endpackage : tsq_pkg

//--- rtl/tsq_clkgen.sv
// clock source selection and prescaler, producing a one-cycle sequencer tick
// assumes source pins are asynchronous and slower than half of pclk
`timescale 1ns/10ps
`default_nettype none
`include "tsq_params.svh"
module tsq_clkgen #(
    parameter int DIV_W = 5,
    parameter logic [2:0] SRC_SYS = 3'h0,
    parameter logic [2:0] SRC_CONV = 3'h1,
    parameter logic [2:0] SRC_PWM = 3'h2,
    parameter logic [2:0] SRC_EXT = 3'h3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic [2:0] src_sel,
    input wire logic [DIV_W-1:0] div,
    input wire logic conv_clk,
    input wire logic pwm_clk,
    input wire logic ext_clk,
    output logic tick
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [2:0] last_r;
    logic [2:0] rise;
    logic src_tick;
    logic [DIV_W-1:0] div_cnt_r;

    // two flops before any edge logic sees a pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
            last_r <= 3'h0;
        end else begin
            meta_r <= {ext_clk, pwm_clk, conv_clk};
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign rise = sync_r & ~last_r;

    always_comb begin
        if (src_sel == SRC_SYS) src_tick = 1'b1;
        else if (src_sel == SRC_CONV) src_tick = rise[0];
        else if (src_sel == SRC_PWM) src_tick = rise[1];
        else if (src_sel == SRC_EXT) src_tick = rise[2];
        else src_tick = 1'b0; // unused codes stop the sequencer
    end

    // ratio is field plus one, so field zero passes every source edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= '0;
            tick <= 1'b0;
        end else if (!enable) begin
            div_cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (src_tick) begin
                if (div_cnt_r == div) begin
                    div_cnt_r <= '0;
                    tick <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 1'b1;
                end
            end
        end
    end
endmodule : tsq_clkgen
`default_nettype wire

//--- sim/tsq_core_properties.sv
// checker of the apb handshake and the step outputs of tsq_core
// assumes binding to tsq_core; sees its ports only
`timescale 1ns/10ps
`default_nettype none
`include "tsq_params.svh"
module tsq_core_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic seq_busy,
    input wire logic step_strobe,
    input wire logic [7:0] step_code
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic en_r;
    logic run_r;
    logic [5:0] idle_r;
    logic mapped;
    assign mapped = paddr[7] || (paddr <= `TSQ_ADDR_ADJ);
    // snooped control bits; only completed writes count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
            run_r <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == `TSQ_ADDR_MAIN) begin
            en_r <= pwdata[`TSQ_BIT_EN];
            run_r <= pwdata[`TSQ_BIT_RUN];
        end
    end
    // generous margin: a slow source may hold busy in the flush state until its next tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_r <= 6'h00;
        end else if (en_r && run_r) begin
            idle_r <= 6'h00;
        end else if (idle_r != 6'h3F) begin
            idle_r <= idle_r + 6'h01;
        end
    end
    AST_PREADY_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_PREADY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    AST_SLVERR_MAP: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == !mapped)
        else $error("error response does not match address map");
    AST_SLVERR_ONLY_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_PRDATA_HOLD: assert property ($changed(prdata) |-> pready && !pwrite && !pslverr)
        else $error("read data changed outside a read");
    AST_CODE_WITH_STROBE: assert property ($changed(step_code) |-> step_strobe)
        else $error("step code changed without a strobe");
    AST_QUIET_STOPPED: assert property (idle_r == 6'h3F |-> !step_strobe && !seq_busy)
        else $error("sequencer active while stopped");
    cover property (step_strobe && step_code[7:5] == 3'h6);
    cover property (pready && pslverr);
    cover property ($fell(seq_busy));
endmodule : tsq_core_chk
bind tsq_core tsq_core_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .seq_busy(seq_busy), .step_strobe(step_strobe),
    .step_code(step_code));
`default_nettype wire

//--- sim/test_trigger_sequencer_core.sv
// self-checking bench of tsq_core driven over apb
// assumes tsq_core_chk is bound from its own file
`timescale 1ns/10ps
`default_nettype none
`include "tsq_params.svh"
module test_trigger_sequencer_core;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seq_busy, step_strobe;
    logic conv_clk, pwm_clk, ext_clk, err;
    logic [7:0] paddr;
    logic [7:0] step_code;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [7:0] got [0:15];
    int stamp [0:15];
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    tsq_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_clk(conv_clk), .pwm_clk(pwm_clk), .ext_clk(ext_clk),
        .seq_busy(seq_busy), .step_strobe(step_strobe), .step_code(step_code));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // source pins at distinct rates so a wrong selection shows in the step spacing
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 0) conv_clk <= ~conv_clk;
        if (cyc % 5 == 0) pwm_clk <= ~pwm_clk;
        if (cyc % 3 == 0) ext_clk <= ~ext_clk;
    end
    task automatic tally_and_finish;
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk
    // bounded wait per strobe; a missing step counts as a mismatch
    task automatic grab(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (step_strobe !== 1'b1 && k < 200);
            got[i] = step_code;
            stamp[i] = cyc;
            if (k >= 200) err_total++;
        end
    endtask : grab
    task automatic t_reset;
        rdchk(`TSQ_ADDR_CLK, 32'h0);
        rdchk(`TSQ_ADDR_QPTR, 32'h0);
        rdchk(`TSQ_ADDR_LIM0, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        // queue is not reset: fill it so no step decodes unknowns
        for (int i = 0; i < 32; i++) wr(8'h80 + 8'(4 * i), 32'h0);
    endtask : t_reset
    task automatic t_loop;
        logic [7:0] e [0:7];
        logic [31:0] q;
        e = '{8'hC0, 8'h00, 8'hC0, 8'h00, 8'hC0, 8'hA0, 8'h00, 8'hC0};
        wr(`TSQ_ADDR_LIM0, 32'h2);
        wr(`TSQ_ADDR_QPTR, 32'h1);
        rdchk(`TSQ_ADDR_QPTR, 32'h1);
        wr(8'h84, 32'hC0);
        wr(8'h88, 32'hA0);
        wr(`TSQ_ADDR_MAIN, 32'h8000);
        repeat (8) @(posedge pclk);
        wr(`TSQ_ADDR_LIM0, 32'h7);
        rdchk(`TSQ_ADDR_LIM0, 32'h2);
        wr(`TSQ_ADDR_MAIN, 32'h8100);
        rdchk(`TSQ_ADDR_LIM0, 32'h0);
        wr(`TSQ_ADDR_MAIN, 32'h8080);
        grab(8);
        for (int i = 0; i < 8; i++) check({24'h0, got[i]}, {24'h0, e[i]});
        wr(`TSQ_ADDR_MAIN, 32'h8000);
        apb(1'b0, `TSQ_ADDR_QPTR, 32'h0);
        q = rd;
        repeat (5) @(posedge pclk);
        rdchk(`TSQ_ADDR_QPTR, q);
        wr(`TSQ_ADDR_QPTR, 32'h2);
        wr(`TSQ_ADDR_MAIN, 32'h8080);
        grab(2);
        check({24'h0, got[0]}, 32'hA0);
        check({24'h0, got[1]}, 32'h00);
        wr(`TSQ_ADDR_MAIN, 32'h0);
        rdchk(`TSQ_ADDR_QPTR, 32'h0);
        wr(`TSQ_ADDR_MAIN, 32'h0100);
        rdchk(`TSQ_ADDR_LIM0, 32'h2);
        wr(`TSQ_ADDR_MAIN, 32'h0);
    endtask : t_loop
    task automatic t_adjust;
        wr(`TSQ_ADDR_HOLD, 32'h1);
        wr(`TSQ_ADDR_ADJ, 32'h3);
        wr(`TSQ_ADDR_LIM1, 32'h0);
        wr(`TSQ_ADDR_QPTR, 32'h10);
        wr(8'hC0, 32'h49);
        wr(8'hC4, 32'h41);
        wr(8'hCC, 32'hF2);
        wr(8'hD0, 32'hB4);
        wr(`TSQ_ADDR_MAIN, 32'h8000);
        repeat (8) @(posedge pclk);
        wr(`TSQ_ADDR_ADJ, 32'h9);
        rdchk(`TSQ_ADDR_ADJ, 32'h3);
        wr(`TSQ_ADDR_MAIN, 32'h8080);
        grab(13);
        check({24'h0, got[0]}, 32'h49);
        check({24'h0, got[1]}, 32'h41);
        for (int i = 2; i < 12; i++) check({24'h0, got[i]}, i[0] ? 32'hF2 : 32'h00);
        check({24'h0, got[12]}, 32'hB4);
        rdchk(`TSQ_ADDR_LIM1, 32'h4);
        wr(`TSQ_ADDR_MAIN, 32'h0);
    endtask : t_adjust
    task automatic t_clock;
        int per [0:3];
        int d;
        int cnt;
        logic [31:0] cw;
        per = '{1, 8, 10, 6};
        for (int k = 0; k < 5; k++) begin
            d = (k == 0) ? 3 : 1;
            cw = {16'h0, 3'(k), 5'(d), 8'h0};
            wr(`TSQ_ADDR_CLK, cw);
            wr(`TSQ_ADDR_QPTR, 32'h8);
            wr(`TSQ_ADDR_MAIN, 32'h8000);
            // start-up delay is four ticks, at most eighty cycles here
            repeat (120) @(posedge pclk);
            wr(`TSQ_ADDR_CLK, 32'hFF00);
            rdchk(`TSQ_ADDR_CLK, cw);
            wr(`TSQ_ADDR_MAIN, 32'h8080);
            if (k < 4) begin
                grab(2);
                check(32'(stamp[1] - stamp[0]), 32'(per[k] * (d + 1)));
            end else begin
                cnt = 0;
                repeat (100) begin
                    @(posedge pclk);
                    if (step_strobe !== 1'b0) cnt++;
                end
                check(32'(cnt), 32'h0);
            end
            wr(`TSQ_ADDR_MAIN, 32'h0);
        end
    endtask : t_clock
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_clk = 1'b0;
        pwm_clk = 1'b0;
        ext_clk = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_loop;
        t_adjust;
        t_clock;
        tally_and_finish;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        err_total++;
        tally_and_finish;
    end
endmodule : test_trigger_sequencer_core
`default_nettype wire
